//--- hdl/scd_pkg.sv
package scd_pkg;

  // source-select fuse codes, all others decoded by range
  localparam logic [3:0] SRC_CODE_INT_RC   = 4'h2;
  localparam logic [3:0] SRC_CODE_EXT_CLK  = 4'h0;
  localparam logic [3:0] SRC_CODE_RSVD_A   = 4'h3;
  localparam logic [3:0] SRC_CODE_RSVD_B   = 4'h1;
  localparam int         SRC_BIT_CRYSTAL   = 3;     // set: crystal or resonator range
  localparam int         SRC_BIT_LOW_FREQ  = 2;     // set with bit 3 clear: low-freq crystal
  localparam int         SRC_BIT_STARTUP   = 0;     // low bit joins the start-up choice

  // start-up field codes
  localparam logic [1:0] SUT_CODE_NONE     = 2'h0;
  localparam logic [1:0] SUT_CODE_SHORT    = 2'h1;
  localparam logic [1:0] SUT_CODE_LONG     = 2'h2;
  localparam logic [1:0] SUT_CODE_RSVD     = 2'h3;

  // delivered fuse state (0 = programmed)
  localparam logic [3:0] FUSE_DEFAULT_SOURCE  = 4'h2;
  localparam logic [1:0] FUSE_DEFAULT_STARTUP = 2'h2;
  localparam logic       FUSE_DEFAULT_DIV8    = 1'h0;
  localparam logic       FUSE_PROGRAMMED      = 1'h0;

  // sleep mode codes on the sleep_mode port
  localparam logic [2:0] SLEEP_IDLE        = 3'h0;
  localparam logic [2:0] SLEEP_ADC_NOISE   = 3'h1;
  localparam logic [2:0] SLEEP_POWER_DOWN  = 3'h2;
  localparam logic [2:0] SLEEP_POWER_SAVE  = 3'h3;
  localparam logic [2:0] SLEEP_STANDBY     = 3'h6;

  // cycle counts, watchdog oscillator and selected source
  localparam int unsigned WDT_SHORT_CYCLES = 4096;
  localparam int unsigned WDT_LONG_CYCLES  = 65536;
  localparam int unsigned CK_RESET_EXTRA   = 14;
  localparam int unsigned CK_WAKE_258      = 258;
  localparam int unsigned CK_WAKE_1K       = 1024;
  localparam int unsigned CK_WAKE_16K      = 16384;
  localparam int unsigned CK_WAKE_32K      = 32768;
  localparam int unsigned CK_WAKE_RC       = 6;
  localparam int unsigned CK_WAKE_EXT      = 6;
  localparam int          COUNT_W          = 17;
  localparam logic [2:0]  PRESCALE_LAST    = 3'h7;  // divide by eight

  typedef enum logic [2:0] {
    SRC_CRYSTAL, SRC_LOW_FREQ, SRC_INT_RC, SRC_EXT_CLOCK, SRC_RESERVED
  } scd_source_type;

endpackage : scd_pkg

//--- hdl/scd_tick_counter.sv
`timescale 1ns/1ps
// counts qualifying ticks up to a limit; done holds until cleared
module scd_tick_counter #(
  parameter int WIDTH = 17
) (
  input  wire logic             clock_i,   // system clock
  input  wire logic             reset_i,   // synchronous, active high
  input  wire logic             clear_i,   // restart count from zero
  input  wire logic             tick_i,    // one counted cycle
  input  wire logic [WIDTH-1:0] limit_i,   // ticks to wait
  output logic                  done_o     // count reached limit
);
  logic [WIDTH-1:0] count_q;
  logic [WIDTH-1:0] count_d;
  logic             at_limit;

  // saturate at limit so a stale tick cannot wrap
  assign at_limit = (count_q >= limit_i);
  assign count_d  = clear_i ? '0 : ((tick_i && !at_limit) ? count_q + 1'b1 : count_q);
  assign done_o   = at_limit;  // not gated by clear: clear is built from done upstream

  always_ff @(posedge clock_i) begin
    if (reset_i) count_q <= '0;
    else         count_q <= count_d;
  end
endmodule : scd_tick_counter

//--- hdl/scd_clock_control.sv
`timescale 1ns/1ps
module scd_clock_control #(
  parameter int unsigned WDT_SHORT = scd_pkg::WDT_SHORT_CYCLES,
  parameter int unsigned WDT_LONG  = scd_pkg::WDT_LONG_CYCLES,
  parameter int unsigned WAKE_16K  = scd_pkg::CK_WAKE_16K,
  parameter int unsigned WAKE_32K  = scd_pkg::CK_WAKE_32K,
  parameter int unsigned WAKE_RC   = scd_pkg::CK_WAKE_RC,
  parameter int unsigned WAKE_EXT  = scd_pkg::CK_WAKE_EXT
) (
  input  wire logic       clock_i,                      // system clock, 10 MHz
  input  wire logic       reset_i,                      // synchronous, active high
  input  wire logic       fuses_erased_i,               // fuse array blank: use defaults
  input  wire logic [3:0] clock_source_select_fuses_i,  // source fuses
  input  wire logic [1:0] startup_time_fuses_i,         // start-up fuses
  input  wire logic       divide_by_eight_fuse_i,       // prescale fuse, 0 programmed
  input  wire logic       source_tick_i,                // one cycle of selected source
  input  wire logic       watchdog_oscillator_tick_i,   // one watchdog oscillator cycle
  input  wire logic       async_source_sel_i,           // 1: external clock, 0: 32k crystal
  input  wire logic       async_ext_tick_i,             // external async clock cycle
  input  wire logic       async_xtal_tick_i,            // 32 kHz crystal cycle
  input  wire logic       sleep_request_i,              // pulse: enter sleep
  input  wire logic [2:0] sleep_mode_i,                 // mode for that request
  input  wire logic       wake_i,                       // other wake source, level
  input  wire logic       ext_int_level_i,              // external interrupt pin level
  input  wire logic       ext_int_async_en_i,           // that input detected async
  input  wire logic       twi_addr_valid_i,             // received address present
  input  wire logic [6:0] twi_rx_addr_i,                // received address
  input  wire logic [6:0] twi_own_addr_i,               // own slave address
  output logic            core_clock_en_o,              // core domain cycle
  output logic            flash_interface_clock_en_o,   // flash domain cycle
  output logic            peripheral_clock_en_o,        // peripheral domain cycle
  output logic            converter_clock_en_o,         // converter domain cycle
  output logic            async_timer_clock_en_o,       // async timer domain cycle
  output logic            core_halted_o,                // core must not execute
  output logic            startup_busy_o,               // start-up timing in progress
  output logic            source_reserved_o,            // fuse code is reserved
  output logic            ext_int_wake_o,               // async external interrupt seen
  output logic            twi_addr_match_o              // own address recognised
);
  localparam int CW = scd_pkg::COUNT_W;

  typedef enum logic [2:0] {
    ST_LATCH, ST_RESET_WDT, ST_RESET_CK, ST_RUN, ST_SLEEP, ST_WAKE
  } scd_state_type;

  scd_state_type          state_q, state_d;
  logic [3:0]             src_fuse_q;
  logic [1:0]             sut_fuse_q;
  logic                   div8_fuse_q;
  logic [2:0]             mode_q;
  logic [2:0]             div_cnt_q;
  logic                   core_en_q, flash_en_q, periph_en_q, adc_en_q, async_en_q;
  logic                   busy_q;
  scd_pkg::scd_source_type src_class;
  logic [CW-1:0]          wdt_limit, wake_limit, cnt_limit;
  logic                   cnt_clear, cnt_tick, cnt_done;
  logic                   sys_tick, deep_mode, wake_any, reserved;
  logic                   core_gate, periph_gate, adc_gate, async_tick;
  logic [3:0]             src_fuse_eff;
  logic [1:0]             sut_fuse_eff;
  logic                   div8_fuse_eff;

  // source class from the fuse field
  function automatic scd_pkg::scd_source_type decode_source(input logic [3:0] f);
    if (f[scd_pkg::SRC_BIT_CRYSTAL])       decode_source = scd_pkg::SRC_CRYSTAL;
    else if (f[scd_pkg::SRC_BIT_LOW_FREQ]) decode_source = scd_pkg::SRC_LOW_FREQ;
    else if (f == scd_pkg::SRC_CODE_INT_RC)  decode_source = scd_pkg::SRC_INT_RC;
    else if (f == scd_pkg::SRC_CODE_EXT_CLK) decode_source = scd_pkg::SRC_EXT_CLOCK;
    else                                   decode_source = scd_pkg::SRC_RESERVED;
  endfunction : decode_source

  // watchdog cycles of the settling delay after reset
  function automatic logic [CW-1:0] reset_wdt_count(input scd_pkg::scd_source_type c,
                                                   input logic [3:0] f, input logic [1:0] s);
    logic [2:0] key;
    key = {f[scd_pkg::SRC_BIT_STARTUP], s};
    reset_wdt_count = CW'(WDT_LONG);
    if (c == scd_pkg::SRC_CRYSTAL) begin
      case (key)
        3'h2, 3'h5:       reset_wdt_count = '0;
        3'h0, 3'h3, 3'h6: reset_wdt_count = CW'(WDT_SHORT);
        default:          reset_wdt_count = CW'(WDT_LONG);
      endcase
    end else begin
      case (s)
        scd_pkg::SUT_CODE_NONE:  reset_wdt_count = '0;
        scd_pkg::SUT_CODE_SHORT: reset_wdt_count = CW'(WDT_SHORT);
        default:                 reset_wdt_count = CW'(WDT_LONG);
      endcase
    end
  endfunction : reset_wdt_count

  // source cycles before execution on wake from deep sleep
  function automatic logic [CW-1:0] wake_count(input scd_pkg::scd_source_type c,
                                              input logic [3:0] f, input logic [1:0] s);
    logic [2:0] key;
    key = {f[scd_pkg::SRC_BIT_STARTUP], s};
    case (c)
      scd_pkg::SRC_CRYSTAL: begin
        if (key < 3'h2)      wake_count = CW'(scd_pkg::CK_WAKE_258);
        else if (key < 3'h5) wake_count = CW'(scd_pkg::CK_WAKE_1K);
        else                 wake_count = CW'(WAKE_16K);
      end
      scd_pkg::SRC_LOW_FREQ:
        wake_count = f[scd_pkg::SRC_BIT_STARTUP] ? CW'(WAKE_32K) : CW'(scd_pkg::CK_WAKE_1K);
      scd_pkg::SRC_INT_RC: wake_count = CW'(WAKE_RC);
      default:             wake_count = CW'(WAKE_EXT);
    endcase
  endfunction : wake_count

  // blank fuse array falls back to the delivered setting
  assign src_fuse_eff  = fuses_erased_i ? scd_pkg::FUSE_DEFAULT_SOURCE  : clock_source_select_fuses_i;
  assign sut_fuse_eff  = fuses_erased_i ? scd_pkg::FUSE_DEFAULT_STARTUP : startup_time_fuses_i;
  assign div8_fuse_eff = fuses_erased_i ? scd_pkg::FUSE_DEFAULT_DIV8    : divide_by_eight_fuse_i;

  // fuses caught once, at the first edge after reset release
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      src_fuse_q  <= scd_pkg::FUSE_DEFAULT_SOURCE;
      sut_fuse_q  <= scd_pkg::FUSE_DEFAULT_STARTUP;
      div8_fuse_q <= scd_pkg::FUSE_DEFAULT_DIV8;
    end else if (state_q == ST_LATCH) begin
      src_fuse_q  <= src_fuse_eff;
      sut_fuse_q  <= sut_fuse_eff;
      div8_fuse_q <= div8_fuse_eff;
    end
  end

  // decoded fuse settings
  assign src_class  = decode_source(src_fuse_q);
  assign reserved   = (src_class == scd_pkg::SRC_RESERVED) ||
                      ((src_class == scd_pkg::SRC_LOW_FREQ) &&
                       (sut_fuse_q == scd_pkg::SUT_CODE_RSVD));
  assign wdt_limit  = reset_wdt_count(src_class, src_fuse_q, sut_fuse_q);
  assign wake_limit = wake_count(src_class, src_fuse_q, sut_fuse_q);

  // wake sources; async paths need no peripheral clock
  assign ext_int_wake_o   = ext_int_level_i && ext_int_async_en_i;
  assign twi_addr_match_o = twi_addr_valid_i && (twi_rx_addr_i == twi_own_addr_i);
  assign wake_any         = wake_i || ext_int_wake_o || twi_addr_match_o;
  assign deep_mode        = (mode_q == scd_pkg::SLEEP_POWER_DOWN) ||
                            (mode_q == scd_pkg::SLEEP_POWER_SAVE) ||
                            (mode_q == scd_pkg::SLEEP_STANDBY);

  // start-up sequencer
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_LATCH:     state_d = ST_RESET_WDT;
      ST_RESET_WDT: if (cnt_done) state_d = ST_RESET_CK;
      ST_RESET_CK:  if (cnt_done && !reserved) state_d = ST_RUN;
      ST_RUN:       if (sleep_request_i) state_d = ST_SLEEP;
      ST_SLEEP:     if (wake_any) state_d = deep_mode ? ST_WAKE : ST_RUN;
      ST_WAKE:      if (cnt_done) state_d = ST_RUN;
      default:      state_d = ST_LATCH;
    endcase
  end

  // one shared counter; it restarts on every state change
  assign cnt_clear = (state_d != state_q);
  assign cnt_tick  = (state_q == ST_RESET_WDT) ? watchdog_oscillator_tick_i : source_tick_i;
  assign cnt_limit = (state_q == ST_RESET_WDT) ? wdt_limit :
                     (state_q == ST_WAKE) ? wake_limit : CW'(scd_pkg::CK_RESET_EXTRA);

  scd_tick_counter #(
    .WIDTH   (CW)
  ) u_counter (
    .clock_i (clock_i),
    .reset_i (reset_i),
    .clear_i (cnt_clear),
    .tick_i  (cnt_tick),
    .limit_i (cnt_limit),
    .done_o  (cnt_done)
  );

  // state, sleep mode and prescaler
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      state_q   <= ST_LATCH;
      mode_q    <= scd_pkg::SLEEP_IDLE;
      div_cnt_q <= 3'h0;
    end else begin
      state_q   <= state_d;
      if (state_q == ST_RUN && sleep_request_i) mode_q <= sleep_mode_i;
      div_cnt_q <= div_cnt_q + 3'h1;
    end
  end

  // programmed prescale fuse reads as zero
  assign sys_tick = (div8_fuse_q == scd_pkg::FUSE_PROGRAMMED) ?
                    (div_cnt_q == scd_pkg::PRESCALE_LAST) : 1'b1;

  // domain gates per state and sleep mode
  assign core_gate   = (state_q == ST_RUN);
  assign periph_gate = core_gate ||
                       (state_q == ST_SLEEP && mode_q == scd_pkg::SLEEP_IDLE);
  assign adc_gate    = periph_gate ||
                       (state_q == ST_SLEEP && mode_q == scd_pkg::SLEEP_ADC_NOISE);
  assign async_tick  = async_source_sel_i ? async_ext_tick_i : async_xtal_tick_i;

  // enables come from flops: each is a whole cycle, never a sliver
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      core_en_q   <= 1'b0;
      flash_en_q  <= 1'b0;
      periph_en_q <= 1'b0;
      adc_en_q    <= 1'b0;
      async_en_q  <= 1'b0;
      busy_q      <= 1'b1;
    end else begin
      core_en_q   <= core_gate && sys_tick;
      flash_en_q  <= core_gate && sys_tick;
      periph_en_q <= periph_gate && sys_tick;
      adc_en_q    <= adc_gate && sys_tick;
      async_en_q  <= async_tick && (state_q != ST_LATCH);
      busy_q      <= (state_d != ST_RUN) && (state_d != ST_SLEEP);
    end
  end

  assign core_clock_en_o            = core_en_q;
  assign flash_interface_clock_en_o = flash_en_q;
  assign peripheral_clock_en_o      = periph_en_q;
  assign converter_clock_en_o       = adc_en_q;
  assign async_timer_clock_en_o     = async_en_q;
  assign startup_busy_o             = busy_q;
  assign core_halted_o              = !core_en_q;
  assign source_reserved_o          = reserved;

  // helper: ticks seen during the reset watchdog phase
  logic [CW-1:0] chk_wdt_seen_q;
  always_ff @(posedge clock_i) begin
    if (reset_i || state_q != ST_RESET_WDT) chk_wdt_seen_q <= '0;
    else if (watchdog_oscillator_tick_i)    chk_wdt_seen_q <= chk_wdt_seen_q + 1'b1;
  end

  chk_flash_follows_core: assert property (@(posedge clock_i) disable iff (reset_i)
    flash_interface_clock_en_o == core_clock_en_o)
    else $error("flash clock differs from core clock");

  chk_core_only_run: assert property (@(posedge clock_i) disable iff (reset_i)
    core_clock_en_o |-> $past(state_q == ST_RUN) && $past(sys_tick))
    else $error("core clock outside run state");

  chk_deep_sleep_stop: assert property (@(posedge clock_i) disable iff (reset_i)
    (state_q == ST_SLEEP && deep_mode) |=> !peripheral_clock_en_o && !converter_clock_en_o)
    else $error("domain clock running in deep sleep");

  chk_noise_mode_adc: assert property (@(posedge clock_i) disable iff (reset_i)
    (state_q == ST_SLEEP && mode_q == scd_pkg::SLEEP_ADC_NOISE && sys_tick)
      |=> converter_clock_en_o && !peripheral_clock_en_o && !core_clock_en_o)
    else $error("noise reduction mode gating wrong");

  chk_wake_holds_core: assert property (@(posedge clock_i) disable iff (reset_i)
    (state_q == ST_WAKE) |-> startup_busy_o ##1 !core_clock_en_o)
    else $error("core runs before wake count ends");

  chk_reset_wdt_count: assert property (@(posedge clock_i) disable iff (reset_i)
    (state_q == ST_RESET_WDT && state_d == ST_RESET_CK) |-> chk_wdt_seen_q >= wdt_limit)
    else $error("reset delay left early");

  chk_short_long_cnt: assert property (@(posedge clock_i) disable iff (reset_i)
    (state_q == ST_RESET_WDT && src_class == scd_pkg::SRC_LOW_FREQ &&
     sut_fuse_q == scd_pkg::SUT_CODE_SHORT)
      |-> chk_wdt_seen_q <= CW'(WDT_SHORT))
    else $error("short reset delay overran");

  chk_async_in_sleep: assert property (@(posedge clock_i) disable iff (reset_i)
    (async_tick && state_q == ST_SLEEP) |=> async_timer_clock_en_o)
    else $error("async timer stopped in sleep");

  chk_ext_int_async: assert property (@(posedge clock_i) disable iff (reset_i)
    (ext_int_level_i && ext_int_async_en_i && !peripheral_clock_en_o) |-> ext_int_wake_o)
    else $error("external interrupt missed while halted");

  chk_twi_addr_match: assert property (@(posedge clock_i) disable iff (reset_i)
    (twi_addr_valid_i && twi_rx_addr_i == twi_own_addr_i) |-> twi_addr_match_o)
    else $error("own address not recognised");

  chk_reserved_no_run: assert property (@(posedge clock_i) disable iff (reset_i)
    reserved |-> state_q != ST_RUN)
    else $error("running on reserved source code");

  chk_div8_spacing: assert property (@(posedge clock_i) disable iff (reset_i)
    (core_clock_en_o && div8_fuse_q == scd_pkg::FUSE_PROGRAMMED) |=> !core_clock_en_o [*7])
    else $error("prescaled core clock too fast");

  chk_whole_pulse: assert property (@(posedge clock_i) disable iff (reset_i)
    $rose(core_clock_en_o) |-> $past(core_gate))
    else $error("core clock edge without gate");

  cov_reach_run: cover property (@(posedge clock_i) disable iff (reset_i)
    state_q == ST_RESET_CK ##1 state_q == ST_RUN);
  cov_deep_wake: cover property (@(posedge clock_i) disable iff (reset_i)
    state_q == ST_WAKE ##1 state_q == ST_RUN);
  cov_idle_wake: cover property (@(posedge clock_i) disable iff (reset_i)
    state_q == ST_SLEEP && mode_q == scd_pkg::SLEEP_IDLE ##1 state_q == ST_RUN);

endmodule : scd_clock_control

//--- bench/scd_osc_model.sv
`timescale 1ns/1ps
// far side: oscillator and watchdog oscillator as single-cycle tick pulses
module scd_osc_model (
  input  wire logic clock_i,        // system clock
  input  wire logic slow_i,         // stretch the selected source period
  output logic      source_tick_o,  // selected source cycle
  output logic      wdt_tick_o,     // watchdog oscillator cycle
  output logic      ext_tick_o,     // external async clock cycle
  output logic      xtal_tick_o     // 32 kHz crystal cycle
);
  logic [7:0] cnt_q = 8'h00;

  // one free counter; periods differ so tick streams drift against each other
  always_ff @(posedge clock_i) begin
    cnt_q <= cnt_q + 8'h01;
  end

  assign source_tick_o = slow_i ? (cnt_q[2:0] == 3'h0) : cnt_q[0];
  assign wdt_tick_o    = (cnt_q % 8'h03) == 8'h00;
  assign ext_tick_o    = cnt_q[1:0] == 2'h3;
  assign xtal_tick_o   = (cnt_q % 8'h05) == 8'h00;
endmodule : scd_osc_model

//--- bench/tb.sv
`timescale 1ns/1ps
module tb;
  logic       clock_i = 1'b0, reset_i = 1'b1, fuses_erased_i = 1'b1, slow = 1'b0;
  logic [3:0] clock_source_select_fuses_i = 4'hF;
  logic [1:0] startup_time_fuses_i = 2'h1;
  logic [2:0] sleep_mode_i = 3'h0;
  logic [6:0] twi_rx_addr_i = 7'h00, twi_own_addr_i = 7'h00;
  logic       divide_by_eight_fuse_i = 1'b1, async_source_sel_i = 1'b1, sleep_request_i = 1'b0;
  logic       wake_i = 1'b0, ext_int_level_i = 1'b0, ext_int_async_en_i = 1'b0;
  logic       twi_addr_valid_i = 1'b0, clr = 1'b0;
  logic       source_tick_i, watchdog_oscillator_tick_i, async_ext_tick_i, async_xtal_tick_i;
  logic       core_clock_en_o, flash_interface_clock_en_o, peripheral_clock_en_o;
  logic       converter_clock_en_o, async_timer_clock_en_o, core_halted_o, startup_busy_o;
  logic       source_reserved_o, ext_int_wake_o, twi_addr_match_o;
  logic [7:0] n_core, n_flash, n_per, n_conv, n_asy;
  logic [31:0] rnd = 32'h3E53;
  int         errors = 0, checks_done = 0;
  typedef struct {int sel; logic [7:0] exp;} note_type;
  note_type   q[$];
  event       snap;
  string      nm[10] = '{"core", "flash", "periph", "conv", "async", "halted", "busy",
                         "reserved", "ext_wake", "twi_match"};

  scd_clock_control #(.WDT_SHORT(4), .WDT_LONG(8), .WAKE_16K(5), .WAKE_32K(7), .WAKE_RC(3),
    .WAKE_EXT(3)) dut (.clock_i, .reset_i, .fuses_erased_i, .clock_source_select_fuses_i,
    .startup_time_fuses_i, .divide_by_eight_fuse_i, .source_tick_i, .watchdog_oscillator_tick_i,
    .async_source_sel_i, .async_ext_tick_i, .async_xtal_tick_i, .sleep_request_i, .sleep_mode_i,
    .wake_i, .ext_int_level_i, .ext_int_async_en_i, .twi_addr_valid_i, .twi_rx_addr_i,
    .twi_own_addr_i, .core_clock_en_o, .flash_interface_clock_en_o, .peripheral_clock_en_o,
    .converter_clock_en_o, .async_timer_clock_en_o, .core_halted_o, .startup_busy_o,
    .source_reserved_o, .ext_int_wake_o, .twi_addr_match_o);

  scd_osc_model osc (.clock_i(clock_i), .slow_i(slow), .source_tick_o(source_tick_i),
    .wdt_tick_o(watchdog_oscillator_tick_i), .ext_tick_o(async_ext_tick_i),
    .xtal_tick_o(async_xtal_tick_i));

  initial begin
    forever #50 clock_i = ~clock_i;
  end

  // pulse counters per domain, cleared on request
  always @(posedge clock_i) begin
    if (clr) begin
      {n_core, n_flash, n_per, n_conv, n_asy} <= '0;
    end else begin
      n_core  <= n_core + {7'h00, core_clock_en_o};
      n_flash <= n_flash + {7'h00, flash_interface_clock_en_o};
      n_per   <= n_per + {7'h00, peripheral_clock_en_o};
      n_conv  <= n_conv + {7'h00, converter_clock_en_o};
      n_asy   <= n_asy + {7'h00, async_timer_clock_en_o};
    end
  end

  // takes the oldest note and compares it with what the outputs show now
  always @(snap) begin
    logic [7:0] obs [10];
    note_type   n;
    obs = '{n_core, n_flash, n_per, n_conv, {7'h00, n_asy != 8'h00}, {7'h00, core_halted_o},
            {7'h00, startup_busy_o}, {7'h00, source_reserved_o}, {7'h00, ext_int_wake_o},
            {7'h00, twi_addr_match_o}};
    n = q.pop_front();
    check(nm[n.sel], obs[n.sel], n.exp);
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // small delay lets the edge's updates land before the monitor looks
  task automatic expect_v(input int sel, input logic [7:0] exp);
    q.push_back('{sel, exp});
    #1 ->snap;
  endtask : expect_v

  task automatic window(input int n);
    clr <= 1'b1;
    @(posedge clock_i);
    clr <= 1'b0;
    repeat (n) @(posedge clock_i);
  endtask : window

  task automatic do_reset(input logic er, input logic [3:0] src, input logic [1:0] startup_time_fuses,
                          input logic d8);
    @(posedge clock_i);
    reset_i <= 1'b1;
    fuses_erased_i <= er;
    clock_source_select_fuses_i <= src;
    startup_time_fuses_i <= startup_time_fuses;
    divide_by_eight_fuse_i <= d8;
    repeat (7) @(posedge clock_i);
    reset_i <= 1'b0;
  endtask : do_reset

  // bounded wait for start-up or wake timing to finish
  task automatic wait_run(input int lim);
    int k;
    k = 0;
    // always pass one edge so the caller's next drive lands on an edge
    do begin
      @(posedge clock_i);
      k++;
    end while (startup_busy_o !== 1'b0 && k < lim);
    check("run_reached", {7'h00, k < lim}, 8'h01);
  endtask : wait_run

  task automatic test_done();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : test_done

  initial begin
    repeat (5000) @(posedge clock_i);
    errors++;
    $display("[FAIL] watchdog expected finish seen timeout");
    test_done();
  end

  initial begin
    logic [7:0] tbl [5][5];
    tbl = '{'{0, 0, 16, 16, 0}, '{1, 0, 0, 16, 0}, '{2, 0, 0, 0, 1}, '{3, 0, 0, 0, 1},
            '{6, 0, 0, 0, 1}};
    // delivered defaults: long watchdog wait, then core divided by eight
    do_reset(1'b1, 4'hF, 2'h1, 1'b1);
    expect_v(6, 8'h01);
    repeat (46) @(posedge clock_i);
    expect_v(6, 8'h01);
    wait_run(100);
    window(16);
    expect_v(0, 8'h02);
    expect_v(1, 8'h02);
    expect_v(7, 8'h00);
    // crystal with no reset delay, prescale fuse unprogrammed: every cycle
    do_reset(1'b0, 4'hF, 2'h1, 1'b1);
    wait_run(60);
    window(16);
    expect_v(0, 8'h10);
    expect_v(2, 8'h10);
    // each sleep mode gates its domains (the three deep modes the same set), then wakes
    for (int m = 0; m < 5; m++) begin
      @(posedge clock_i);
      rnd = lfsr(rnd);
      sleep_request_i <= 1'b1;
      sleep_mode_i <= tbl[m][0][2:0];
      async_source_sel_i <= rnd[0];
      slow <= rnd[8];
      twi_own_addr_i <= rnd[7:1];
      twi_rx_addr_i <= rnd[7:1] ^ 7'h01;
      twi_addr_valid_i <= 1'b1;
      @(posedge clock_i);
      sleep_request_i <= 1'b0;
      @(posedge clock_i);
      window(16);
      expect_v(0, tbl[m][1]);
      expect_v(1, tbl[m][1]);
      expect_v(2, tbl[m][2]);
      expect_v(3, tbl[m][3]);
      expect_v(4, 8'h01);
      expect_v(5, 8'h01);
      expect_v(9, 8'h00);
      @(posedge clock_i);
      wake_i <= (m < 3);
      ext_int_level_i <= (m == 3);
      ext_int_async_en_i <= (m == 3);
      twi_rx_addr_i <= (m == 4) ? twi_own_addr_i : twi_rx_addr_i;
      repeat (3) @(posedge clock_i);
      expect_v(6, tbl[m][4]);
      expect_v(8, {7'h00, m == 3});
      expect_v(9, {7'h00, m == 4});
      wait_run(60);
      wake_i <= 1'b0;
      ext_int_level_i <= 1'b0;
      twi_addr_valid_i <= 1'b0;
      slow <= 1'b0;
      window(16);
      expect_v(0, 8'h10);
    end
    // reserved codes never start the core; other sources do, the last one prescaled
    for (int c = 0; c < 4; c++) begin
      do_reset(1'b0, (c == 0) ? 4'h3 : (c == 1) ? 4'h1 : (c == 2) ? 4'h5 : 4'h0,
               (c == 2) ? 2'h1 : 2'h0, c != 3);
      repeat (100) @(posedge clock_i);
      window(16);
      expect_v(7, {7'h00, c < 2});
      expect_v(6, {7'h00, c < 2});
      expect_v(0, (c < 2) ? 8'h00 : (c == 3) ? 8'h02 : 8'h10);
    end
    test_done();
  end
endmodule : tb
